// ---- test/can_bus_node.sv ----
// Purpose: behavioural model of the other nodes on the can bus
// Assumes: one sampled bit every four ref_clk cycles, 1 = recessive
// Notes: talk puts a frame on the bus; its bits toggle so no sync forms
`timescale 1ns/100ps
module can_bus_node (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // bench control
    input  wire logic talk,
    // towards the controller
    output logic      rx_bit,
    output logic      rx_bit_valid,
    output logic      rx_busy,
    output logic      bus_activity
);
    logic [1:0] phase;
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rx_bit <= 1'b1;
        else if (phase == 2'h3)
            rx_bit <= talk ? ~rx_bit : 1'b1;
    end
    // bit changes on the edge that raises its valid pulse, so it is settled when sampled
    assign rx_bit_valid = (phase == 2'h0);
    assign rx_busy      = talk;
    assign bus_activity = talk;
endmodule : can_bus_node

// ---- test/can_mode_ctrl_asserts.sv ----
// Purpose: port-level checks for can_mode_ctrl
// Assumes: one clock ref_clk, async active-low reset arst_n
// Notes: bit length is judged in quanta counted between bit starts
`timescale 1ns/100ps
module can_mode_ctrl_asserts
    import can_mode_pkg::*;
#(
    parameter int N_TX_BUF = 3
)(
    // clock and reset
    input wire logic                ref_clk,
    input wire logic                arst_n,
    // register port
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    // engine and cpu
    input wire logic                rx_busy,
    input wire logic [N_TX_BUF-1:0] tx_buf_full,
    input wire logic                bus_off,
    input wire logic                bus_activity,
    input wire logic                cpu_stop,
    // outputs watched
    input wire logic                engine_abort,
    input wire logic                bus_synced,
    input wire logic                sleep_mode,
    input wire logic                tq_tick,
    input wire logic                bit_start,
    input wire logic                bus_transmit_pin
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    logic [5:0] tq_cnt;
    logic       seen;
    // first bit after init or sleep may be partial, so it only arms the check
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tq_cnt <= 6'h00;
            seen   <= 1'b0;
        end
        else if (bit_start)
        begin
            tq_cnt <= 6'h00;
            seen   <= !engine_abort;
        end
        else if (engine_abort || sleep_mode)
            seen <= 1'b0;
        else if (tq_tick && tq_cnt != 6'h3F)
            tq_cnt <= tq_cnt + 6'h01;
    end

    sequence init_wr;
        reg_wr && reg_addr == OFS_MODE_REQ && reg_wdata[BIT_INIT_REQ];
    endsequence
    sequence sleep_entry;
        $rose(sleep_mode);
    endsequence

    init_pin_a: assert property (init_wr |=> bus_transmit_pin[*2])
        else $error("pin not recessive after init request");
    init_abort_a: assert property (init_wr |=> engine_abort[*2])
        else $error("traffic not aborted on init request");
    sync_drop_a: assert property (engine_abort |=> !bus_synced)
        else $error("sync kept during init");
    stop_pin_a: assert property (cpu_stop |-> bus_transmit_pin)
        else $error("pin not recessive in stop");
    sleep_idle_a: assert property (sleep_entry |->
        !$past(rx_busy) && $past(tx_buf_full) == {N_TX_BUF{1'b0}})
        else $error("sleep entered while bus busy");
    sleep_busy_a: assert property (!sleep_mode &&
        (rx_busy || tx_buf_full != {N_TX_BUF{1'b0}}) |=> !sleep_mode)
        else $error("sleep entered with traffic pending");
    sleep_hold_a: assert property (
        sleep_mode && !bus_activity && !$past(bus_activity) &&
        !reg_wr && !$past(reg_wr) |=> sleep_mode)
        else $error("sleep left without cause");
    sync_busoff_a: assert property ($rose(bus_synced) |->
        !$past(bus_off))
        else $error("sync while bus-off");
    bit_len_a: assert property (bit_start && seen |->
        tq_cnt inside {[6:24]})
        else $error("bit length outside segment limits");
endmodule : can_mode_ctrl_asserts

bind can_mode_ctrl can_mode_ctrl_asserts #(.N_TX_BUF(N_TX_BUF))
    u_can_mode_ctrl_asserts (.ref_clk, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .rx_busy, .tx_buf_full, .bus_off, .bus_activity, .cpu_stop,
    .engine_abort, .bus_synced, .sleep_mode, .tq_tick, .bit_start,
    .bus_transmit_pin);

// ---- test/can_mode_ctrl_test.sv ----
// Purpose: self-checking bench for can_mode_ctrl
// Assumes: register port as handed over, one 100 MHz clock
// Notes: the state inputs are tied low
`timescale 1ns/100ps
module can_mode_ctrl_test;
    import can_mode_pkg::*;
    logic       ref_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [2:0] tx_buf_full = 3'h0;
    logic       engine_tx_bit = 1'b1;
    logic       cpu_stop = 1'b0;
    logic       cpu_wait = 1'b0;
    logic       talk = 1'b0;
    logic       bus_off = 1'b0;
    wire logic [7:0] reg_rdata;
    wire logic  rx_busy, rx_bit, rx_bit_valid, bus_activity;
    wire logic  engine_abort, bus_synced, sleep_mode, tq_tick;
    wire logic  bit_start, sample_point, bus_transmit_pin;
    int         err_count = 0;
    int         cmp_count = 0;

    can_mode_ctrl #(.N_TX_BUF(3)) u_can_mode_ctrl (
        .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .rx_busy, .tx_buf_full, .bus_off, .bus_activity,
        .rx_bit, .rx_bit_valid, .transmitter_state(8'h00),
        .receiver_state(8'h00), .engine_tx_bit, .cpu_stop, .cpu_wait,
        .engine_abort, .bus_synced, .sleep_mode, .tq_tick, .bit_start,
        .sample_point, .bus_transmit_pin);
    can_bus_node u_can_bus_node (.ref_clk, .arst_n, .talk, .rx_bit,
        .rx_bit_valid, .rx_busy, .bus_activity);

    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd
    // cycles from one pulse to the next, of tq_tick or of bit_start
    task automatic span(input bit q, output int n);
        n = 0;
        while (!(q ? tq_tick : bit_start) && n < 200)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (!(q ? tq_tick : bit_start) && n < 200);
    endtask : span
    task automatic conclude();
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic t_config();
        rd(OFS_MODE_REQ, 8'h01);
        rd(OFS_SECONDARY, 8'h01);
        rd(OFS_TX_FLAGS, 8'h07);
        rd(8'h20, 8'h00);
        wr(OFS_BT_FIRST, 8'h01);
        wr(OFS_BT_SECOND, 8'h23);
        rd(OFS_BT_SECOND, 8'h23);
        wr(OFS_MODE_REQ, 8'h00);
        rd(OFS_SECONDARY, 8'h00);
        chk({7'h00, bus_synced}, 8'h00);
        wr(OFS_BT_SECOND, 8'h44);
        rd(OFS_BT_SECOND, 8'h23);
        wr(OFS_ACC_CODE, 8'h55);
        rd(OFS_ACC_CODE, 8'h00);
        repeat (50) @(posedge ref_clk);
        #1;
        chk({7'h00, bus_synced}, 8'h01);
    endtask : t_config
    task automatic t_timing();
        int n;
        span(1'b1, n);
        chk(8'(n), 8'h02);
        span(1'b0, n);
        chk(8'(n), 8'h10);
    endtask : t_timing
    task automatic t_sleep();
        wr(OFS_RX_IEN, 8'h80);
        tx_buf_full <= 3'h4;
        wr(OFS_MODE_REQ, 8'h06);
        rd(OFS_SECONDARY, 8'h00);
        wr(OFS_MODE_REQ, 8'h04);
        rd(OFS_MODE_REQ, 8'h06);
        tx_buf_full <= 3'h0;
        talk        <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(OFS_SECONDARY, 8'h00);
        talk <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(OFS_SECONDARY, 8'h02);
        chk({7'h00, sleep_mode}, 8'h01);
        talk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(OFS_MODE_REQ, 8'h04);
        rd(OFS_SECONDARY, 8'h00);
        rd(OFS_RX_FLAGS, 8'h80);
        talk <= 1'b0;
        wr(OFS_MODE_REQ, 8'h06);
        rd(OFS_MODE_REQ, 8'h04);
        wr(OFS_RX_FLAGS, 8'h80);
        rd(OFS_RX_FLAGS, 8'h00);
    endtask : t_sleep
    task automatic t_init();
        engine_tx_bit <= 1'b0;
        cpu_wait      <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({7'h00, bus_transmit_pin}, 8'h00);
        wr(OFS_MODE_REQ, 8'h84);
        chk({7'h00, bus_transmit_pin}, 8'h01);
        cpu_wait <= 1'b0;
        wr(OFS_MODE_REQ, 8'h04);
        cpu_stop <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({7'h00, bus_transmit_pin}, 8'h01);
        cpu_stop <= 1'b0;
        wr(OFS_MODE_REQ, 8'h05);
        chk({7'h00, bus_transmit_pin}, 8'h01);
        chk({7'h00, engine_abort}, 8'h01);
        rd(OFS_SECONDARY, 8'h01);
        rd(OFS_RX_IEN, 8'h00);
        rd(OFS_MODE_REQ, 8'h05);
        chk({7'h00, bus_synced}, 8'h00);
        bus_off <= 1'b1;
        wr(OFS_MODE_REQ, 8'h04);
        repeat (50) @(posedge ref_clk);
        #1;
        chk({7'h00, bus_synced}, 8'h00);
        bus_off <= 1'b0;
        wr(OFS_MODE_REQ, 8'h06);
        wr(OFS_MODE_REQ, 8'h05);
        rd(OFS_SECONDARY, 8'h01);
    endtask : t_init

    initial
    begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_config();
        t_timing();
        t_sleep();
        t_init();
        conclude();
    end
    initial
    begin
        #100000;
        err_count++;
        conclude();
    end
endmodule : can_mode_ctrl_test

// ---- verilog/can_mode_ctrl.sv ----
// Purpose: mode control, write protection and bit timing of a can controller
// Assumes: register port synchronous to ref_clk, read data one cycle later
// Notes: the protocol engine sits outside; it reports idle, bus-off, bus
//        activity and sampled bits, and receives sync and abort levels
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module can_mode_ctrl
    import can_mode_pkg::*;
#(
    parameter int N_TX_BUF = 3
)(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // protocol engine status
    input  wire logic        rx_busy,
    input  wire logic [N_TX_BUF-1:0] tx_buf_full,
    input  wire logic        bus_off,
    input  wire logic        bus_activity,
    input  wire logic        rx_bit,
    input  wire logic        rx_bit_valid,
    input  wire logic [7:0]  transmitter_state,
    input  wire logic [7:0]  receiver_state,
    input  wire logic        engine_tx_bit,
    // cpu power state
    input  wire logic        cpu_stop,
    input  wire logic        cpu_wait,
    // protocol engine control
    output logic             engine_abort,
    output logic             bus_synced,
    output logic             sleep_mode,
    output logic             tq_tick,
    output logic             bit_start,
    output logic             sample_point,
    // pin
    output logic             bus_transmit_pin
);

    typedef enum logic [1:0] {
        ST_INIT  = 2'b00,
        ST_RUN   = 2'b01,
        ST_SLEEP = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        SEG_SYNC = 2'b00,
        SEG_ONE  = 2'b01,
        SEG_TWO  = 2'b10
    } seg_t;

    mode_t      mode;
    seg_t       seg;
    logic [7:0] mode_request_control;
    logic [7:0] secondary_control;
    logic [7:0] bit_timing_first;
    logic [7:0] bit_timing_second;
    logic [7:0] receive_flags;
    logic [7:0] receive_irq_enables;
    logic [7:0] transmit_flags;
    logic [7:0] transmit_irq_enables;
    logic [7:0] transmit_abort_request;
    logic [7:0] transmit_abort_ack;
    logic [7:0] transmit_buffer_select;
    logic [7:0] acceptance_control;
    logic [7:0] acceptance_codes [8];
    logic [7:0] acceptance_masks [8];
    logic [5:0] presc_cnt;
    logic [3:0] tq_cnt;
    logic [3:0] recessive_cnt;
    logic       init_request;
    logic       sleep_request;
    logic       init_acknowledge;
    logic       sleep_acknowledge;
    logic       wakeup_flag;
    logic       bus_idle;
    logic       in_init;
    logic       cfg_wr;
    logic       sleep_clr_ok;
    logic       init_clr_ok;
    logic [3:0] first_time_segment_last;
    logic [2:0] second_time_segment_last;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return reg_wr && (a == ofs);
    endfunction : hit

    assign init_request      = mode_request_control[BIT_INIT_REQ];
    assign sleep_request     = mode_request_control[BIT_SLEEP_REQ];
    assign init_acknowledge  = secondary_control[BIT_INIT_ACK];
    assign sleep_acknowledge = secondary_control[BIT_SLEEP_ACK];
    assign wakeup_flag       = receive_flags[BIT_WAKEUP_FLAG];
    assign bus_idle     = !rx_busy && (tx_buf_full == '0);
    assign in_init      = init_request && init_acknowledge;
    assign cfg_wr       = reg_wr && in_init;
    assign sleep_clr_ok = sleep_request && sleep_acknowledge;
    assign init_clr_ok  = init_request && init_acknowledge;
    // first segment 4..16 quanta, field holds quanta minus one
    assign first_time_segment_last = (bit_timing_second[BT_FIRST_TIME_SEGMENT_LSB +: 4] < 4'd3) ?
                        4'd3 : bit_timing_second[BT_FIRST_TIME_SEGMENT_LSB +: 4];
    assign second_time_segment_last = (bit_timing_second[BT_SECOND_TIME_SEGMENT_LSB +: 3] < 3'd1) ?
                        3'd1 : bit_timing_second[BT_SECOND_TIME_SEGMENT_LSB +: 3];

    // mode requests; hardware events win over cpu writes
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            mode_request_control <= RST_MODE_REQ;
        else
        begin
            if (hit(reg_addr, OFS_MODE_REQ))
            begin
                if (!init_acknowledge)
                    mode_request_control[7:3] <= reg_wdata[7:3];
                mode_request_control[BIT_WAKEUP_EN] <=
                    reg_wdata[BIT_WAKEUP_EN];
                // request taken in same cycle, pin follows at once
                if (reg_wdata[BIT_INIT_REQ] || init_clr_ok)
                    mode_request_control[BIT_INIT_REQ] <=
                        reg_wdata[BIT_INIT_REQ];
                if (reg_wdata[BIT_SLEEP_REQ] && !wakeup_flag)
                    mode_request_control[BIT_SLEEP_REQ] <= 1'b1;
                else if (!reg_wdata[BIT_SLEEP_REQ] && sleep_clr_ok)
                    mode_request_control[BIT_SLEEP_REQ] <= 1'b0;
            end
            // bus wakeup clears the request itself
            if (mode == ST_SLEEP && bus_activity &&
                mode_request_control[BIT_WAKEUP_EN])
                mode_request_control[BIT_SLEEP_REQ] <= 1'b0;
            // reset in init, keeping wake enable and requests
            if (in_init && !hit(reg_addr, OFS_MODE_REQ))
                mode_request_control[7:3] <= RST_MODE_REQ[7:3];
        end
    end

    // mode state and acknowledge flags
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode              <= ST_INIT;
            secondary_control <= RST_SECONDARY;
        end
        else
        begin
            case (mode)
                ST_INIT:
                begin
                    if (!init_request)
                    begin
                        mode                           <= ST_RUN;
                        secondary_control[BIT_INIT_ACK] <= 1'b0;
                    end
                end
                ST_RUN:
                begin
                    if (init_request)
                    begin
                        mode <= ST_INIT;
                        secondary_control[BIT_INIT_ACK] <= 1'b1;
                    end
                    else if (sleep_request && bus_idle)
                    begin
                        mode <= ST_SLEEP;
                        secondary_control[BIT_SLEEP_ACK] <= 1'b1;
                    end
                end
                ST_SLEEP:
                begin
                    if (init_request)
                    begin
                        mode                           <= ST_INIT;
                        secondary_control[BIT_INIT_ACK] <= 1'b1;
                        // leaving sleep for init drops its ack
                        secondary_control[BIT_SLEEP_ACK] <= 1'b0;
                    end
                    else if (!sleep_request)
                    begin
                        mode                            <= ST_RUN;
                        secondary_control[BIT_SLEEP_ACK] <= 1'b0;
                    end
                end
                default:
                    mode <= ST_INIT;
            endcase
            if (cfg_wr && reg_addr == OFS_SECONDARY)
                secondary_control[7:2] <= reg_wdata[7:2];
        end
    end

    // config registers, written only in init
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bit_timing_first   <= RST_ZERO;
            bit_timing_second  <= RST_ZERO;
            acceptance_control <= RST_ZERO;
        end
        else if (cfg_wr)
        begin
            if (reg_addr == OFS_BT_FIRST)
                bit_timing_first <= reg_wdata;
            if (reg_addr == OFS_BT_SECOND)
                bit_timing_second <= reg_wdata;
            if (reg_addr == OFS_ACC_CTRL)
                acceptance_control <= reg_wdata;
        end
    end

    for (genvar i = 0; i < 8; i++)
    begin : g_filter
        always_ff @(posedge ref_clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                acceptance_codes[i] <= RST_ZERO;
                acceptance_masks[i] <= RST_ZERO;
            end
            else if (cfg_wr)
            begin
                if (reg_addr == OFS_ACC_CODE + 8'(i))
                    acceptance_codes[i] <= reg_wdata;
                if (reg_addr == OFS_ACC_MASK + 8'(i))
                    acceptance_masks[i] <= reg_wdata;
            end
        end
    end

    // flag and enable registers; forces them to reset in init
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            receive_flags          <= RST_ZERO;
            receive_irq_enables    <= RST_ZERO;
            transmit_flags         <= RST_TX_FLAGS;
            transmit_irq_enables   <= RST_ZERO;
            transmit_abort_request <= RST_ZERO;
            transmit_abort_ack     <= RST_ZERO;
            transmit_buffer_select <= RST_BUF_SEL;
        end
        // init reset of flags and enables
        else if (in_init)
        begin
            receive_flags          <= RST_ZERO;
            receive_irq_enables    <= RST_ZERO;
            transmit_flags         <= RST_TX_FLAGS;
            transmit_irq_enables   <= RST_ZERO;
            transmit_abort_request <= RST_ZERO;
            transmit_abort_ack     <= RST_ZERO;
            transmit_buffer_select <= RST_BUF_SEL;
        end
        else
        begin
            // wakeup flag: write one clears, bus activity in sleep sets
            if (hit(reg_addr, OFS_RX_FLAGS))
                receive_flags <= receive_flags & ~reg_wdata;
            if (mode == ST_SLEEP && bus_activity &&
                mode_request_control[BIT_WAKEUP_EN])
                receive_flags[BIT_WAKEUP_FLAG] <= 1'b1;
            if (hit(reg_addr, OFS_RX_IEN))
                receive_irq_enables <= reg_wdata;
            if (hit(reg_addr, OFS_TX_FLAGS))
                transmit_flags <= transmit_flags & ~reg_wdata;
            if (hit(reg_addr, OFS_TX_IEN))
                transmit_irq_enables <= reg_wdata;
            if (hit(reg_addr, OFS_ABORT_REQ))
                transmit_abort_request <= reg_wdata;
            if (hit(reg_addr, OFS_BUF_SEL))
                transmit_buffer_select <= reg_wdata;
        end
    end

    // ref_clk (oscillator clock) over field plus one gives quanta
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            presc_cnt <= 6'h00;
        else if (mode != ST_RUN || presc_cnt >= bit_timing_first[5:0])
            presc_cnt <= 6'h00;
        else
            presc_cnt <= presc_cnt + 6'h01;
    end
    assign tq_tick = (mode == ST_RUN) && (presc_cnt >= bit_timing_first[5:0]);

    // sync segment then both time segments; sets the bit rate
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seg    <= SEG_SYNC;
            tq_cnt <= 4'h0;
        end
        else if (mode != ST_RUN)
        begin
            seg    <= SEG_SYNC;
            tq_cnt <= 4'h0;
        end
        else if (tq_tick)
        begin
            case (seg)
                SEG_SYNC:
                begin
                    seg    <= SEG_ONE;
                    tq_cnt <= 4'h0;
                end
                SEG_ONE:
                begin
                    tq_cnt <= tq_cnt + 4'h1;
                    if (tq_cnt == first_time_segment_last)
                    begin
                        seg    <= SEG_TWO;
                        tq_cnt <= 4'h0;
                    end
                end
                SEG_TWO:
                begin
                    tq_cnt <= tq_cnt + 4'h1;
                    if (tq_cnt == {1'b0, second_time_segment_last})
                    begin
                        seg    <= SEG_SYNC;
                        tq_cnt <= 4'h0;
                    end
                end
                default:
                    seg <= SEG_SYNC;
            endcase
        end
    end
    assign bit_start    = tq_tick && seg == SEG_SYNC;
    assign sample_point = tq_tick && seg == SEG_ONE && tq_cnt == first_time_segment_last;

    // resync after eleven recessive bits when not bus-off
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            recessive_cnt <= 4'h0;
            bus_synced    <= 1'b0;
        end
        else if (mode == ST_INIT || init_request)
        begin
            recessive_cnt <= 4'h0;
            bus_synced    <= 1'b0;
        end
        else if (!bus_synced && !bus_off && rx_bit_valid)
        begin
            if (!rx_bit)
                recessive_cnt <= 4'h0;
            else if (recessive_cnt == 4'(SYNC_RECESSIVE_BITS - 1))
                bus_synced <= 1'b1;
            else
                recessive_cnt <= recessive_cnt + 4'h1;
        end
    end

    assign engine_abort = init_request || mode == ST_INIT;
    assign sleep_mode   = mode == ST_SLEEP;

    // recessive (high) on init request, stop, or wait with stop_in_wait
    assign bus_transmit_pin = (init_request || cpu_stop ||
                               (cpu_wait && mode_request_control[7]) ||
                               mode != ST_RUN) ? 1'b1 : engine_tx_bit;

    // read port, one cycle latency; unmapped reads zero
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (!reg_rd)
            reg_rdata <= 8'h00;
        else if (reg_addr >= OFS_ACC_CODE && reg_addr < OFS_ACC_MASK)
            reg_rdata <= acceptance_codes[reg_addr[2:0]];
        else if (reg_addr >= OFS_ACC_MASK && reg_addr < OFS_ACC_MASK + 8'h08)
            reg_rdata <= acceptance_masks[reg_addr[2:0]];
        else
            case (reg_addr)
                OFS_MODE_REQ:  reg_rdata <= mode_request_control;
                OFS_SECONDARY: reg_rdata <= secondary_control;
                OFS_BT_FIRST:  reg_rdata <= bit_timing_first;
                OFS_BT_SECOND: reg_rdata <= bit_timing_second;
                OFS_RX_FLAGS:  reg_rdata <= receive_flags;
                OFS_RX_IEN:    reg_rdata <= receive_irq_enables;
                OFS_TX_FLAGS:  reg_rdata <= transmit_flags;
                OFS_TX_IEN:    reg_rdata <= transmit_irq_enables;
                OFS_ABORT_REQ: reg_rdata <= transmit_abort_request;
                OFS_ABORT_ACK: reg_rdata <= transmit_abort_ack;
                OFS_BUF_SEL:   reg_rdata <= transmit_buffer_select;
                OFS_ACC_CTRL:  reg_rdata <= acceptance_control;
                // upper nibbles of transmitter/receiver state pass through untouched by init
                OFS_STATE:     reg_rdata <= {transmitter_state[7:4],
                                             receiver_state[7:4]};
                default:       reg_rdata <= 8'h00;
            endcase
    end

endmodule : can_mode_ctrl

// ---- verilog/can_mode_pkg.sv ----
// Purpose: constants for the can mode control and bit timing block
// Assumes: 8-bit register port, byte-wide registers at word-free offsets
// Notes: offsets are local choices; see module for behaviour
package can_mode_pkg;
    localparam logic [7:0] OFS_MODE_REQ   = 8'h00;
    localparam logic [7:0] OFS_SECONDARY  = 8'h01;
    localparam logic [7:0] OFS_BT_FIRST   = 8'h02;
    localparam logic [7:0] OFS_BT_SECOND  = 8'h03;
    localparam logic [7:0] OFS_RX_FLAGS   = 8'h04;
    localparam logic [7:0] OFS_RX_IEN     = 8'h05;
    localparam logic [7:0] OFS_TX_FLAGS   = 8'h06;
    localparam logic [7:0] OFS_TX_IEN     = 8'h07;
    localparam logic [7:0] OFS_ABORT_REQ  = 8'h08;
    localparam logic [7:0] OFS_ABORT_ACK  = 8'h09;
    localparam logic [7:0] OFS_BUF_SEL    = 8'h0A;
    localparam logic [7:0] OFS_ACC_CTRL   = 8'h0B;
    localparam logic [7:0] OFS_STATE      = 8'h0C;
    localparam logic [7:0] OFS_ACC_CODE   = 8'h10;
    localparam logic [7:0] OFS_ACC_MASK   = 8'h18;
    // mode_request_control fields
    localparam int BIT_INIT_REQ    = 0;
    localparam int BIT_SLEEP_REQ   = 1;
    localparam int BIT_WAKEUP_EN   = 2;
    // secondary_control fields
    localparam int BIT_INIT_ACK    = 0;
    localparam int BIT_SLEEP_ACK   = 1;
    // receive_flags fields
    localparam int BIT_WAKEUP_FLAG = 7;
    // receive_irq_enables fields
    localparam int BIT_WAKEUP_IEN  = 7;
    // bit_timing_second fields: first segment [3:0], second segment [6:4]
    localparam int BT_FIRST_TIME_SEGMENT_LSB    = 0;
    localparam int BT_SECOND_TIME_SEGMENT_LSB    = 4;
    localparam logic [7:0] RST_MODE_REQ  = 8'h01;
    localparam logic [7:0] RST_SECONDARY = 8'h01;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_TX_FLAGS  = 8'h07;
    localparam logic [7:0] RST_BUF_SEL   = 8'h00;
    localparam int SYNC_RECESSIVE_BITS = 11;
    localparam logic [7:0] MASK_INIT_KEEP = 8'h07;
endpackage : can_mode_pkg
